// ==== verification/sgob_host_model.sv ====
// host controller model driving the command pulse pins
`timescale 1ns/1ps
module sgob_host_model
  import sgob_pkg::*;
(
  // clock and drive status
  input wire logic clk,
  input wire logic servo_on_req,
  input wire logic brake_interlock_output,
  // command pulse pins
  output logic cmd_a_pin,
  output logic cmd_b_pin
);
  // pins idle low
  initial
  begin
    cmd_a_pin = 1'b0;
    cmd_b_pin = 1'b0;
  end
  // one pin change after a gap long enough for the largest ratio used
  task automatic step(input logic a, input logic b);
    repeat (40) @(posedge clk);
    #1;
    cmd_a_pin = a;
    cmd_b_pin = b;
  endtask
  // send n command units; commands wait for the brake after a servo-on request
  task automatic send(input int n, input logic fwd, input sgob_pmode_t m);
    if (servo_on_req)
      wait (brake_interlock_output);
    repeat (n)
    begin
      case (m)
        SGOB_IN_QUAD:
        begin
          step(fwd, !fwd);
          step(1'b1, 1'b1);
          step(!fwd, fwd);
          step(1'b0, 1'b0);
        end
        SGOB_IN_UPDOWN:
        begin
          step(fwd, !fwd);
          step(1'b0, 1'b0);
        end
        default:
        begin
          step(1'b0, fwd);
          step(1'b1, fwd);
          step(1'b0, 1'b0);
        end
      endcase
    end
  endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the servo gear, overrun and brake block
`timescale 1ns/1ps
module tb;
  import sgob_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic servo_on_req = 1'b0;
  logic deviation_clear = 1'b0;
  logic autotune_active = 1'b0;
  logic cmd_a_pin, cmd_b_pin, cmd_step, cmd_dir, motor_energized, brake_interlock_output;
  sgob_gear_cfg_t gear_cfg = '0;
  sgob_pmode_t command_pulse_mode = SGOB_IN_PULSE_DIR;
  logic [31:0] overrun_range_setting = 32'h0;
  logic [3:0] control_mode_select = 4'h0;
  logic [3:0] drive_prohibit_stop_select = 4'h2;
  // short delay as for a horizontal axis; a vertical axis sets it above the brake engagement time
  logic [15:0] stopped_brake_delay = 16'h0001;
  logic [15:0] running_brake_wait = 16'hFFFF;
  logic [15:0] motor_speed = 16'h0000;
  logic signed [31:0] motor_position = 32'sh0;
  logic signed [31:0] command_position;
  sgob_alarm_t alarm;
  int num_errors = 0;
  int comparisons = 0;
  int steps = 0;
  logic [31:0] seed = 32'h7B2A;
  // 50 MHz clock
  always #10 clk = ~clk;
  // counts internal command pulses on the step output
  always @(posedge clk)
    if (cmd_step === 1'b1)
      steps++;
  sgob_servo_logic i_dut (.clk(clk), .rst_n(rst_n), .cmd_a_pin(cmd_a_pin), .cmd_b_pin(cmd_b_pin),
    .gear_cfg(gear_cfg), .command_pulse_mode(command_pulse_mode), .overrun_range_setting(overrun_range_setting),
    .control_mode_select(control_mode_select), .drive_prohibit_stop_select(drive_prohibit_stop_select),
    .stopped_brake_delay(stopped_brake_delay), .running_brake_wait(running_brake_wait),
    .servo_on_req(servo_on_req), .motor_speed(motor_speed), .motor_position(motor_position),
    .deviation_clear(deviation_clear), .autotune_active(autotune_active), .cmd_step(cmd_step),
    .cmd_dir(cmd_dir), .command_position(command_position), .motor_energized(motor_energized),
    .brake_interlock_output(brake_interlock_output), .alarm(alarm));
  sgob_host_model i_host (.clk(clk), .servo_on_req(servo_on_req),
    .brake_interlock_output(brake_interlock_output), .cmd_a_pin(cmd_a_pin), .cmd_b_pin(cmd_b_pin));
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // expected counts: settings clamped, zero numerator gives 4 x 2500 counts per rotation
  function automatic int gear_expect(input int n, input logic [13:0] num, input logic [4:0] ex,
    input logic [13:0] den);
    longint nv;
    longint dv;
    nv = (num > 14'h2710) ? 64'h2710 : 64'(num);
    nv = (num == 14'h0) ? 64'h2710 : (nv << ex);
    dv = (den == 14'h0) ? 64'h1 : ((den > 14'h2710) ? 64'h2710 : 64'(den));
    return int'((n * nv) / dv);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    comparisons++;
    if (got !== want)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %0h want %0h", $time, what, got, want);
    end
  endtask
  task automatic reset_dut();
    rst_n = 1'b0;
    tick(16);
    rst_n = 1'b1;
    tick(2);
  endtask
  // send n units on a fresh design and compare the distance travelled
  task automatic gear(input int n, input logic fwd, input sgob_pmode_t m, input logic [31:0] want);
    reset_dut();
    command_pulse_mode = m;
    steps = 0;
    i_host.send(n, fwd, m);
    tick(80);
    chk(fwd ? command_position : -command_position, want, "position");
    chk(steps, want, "step pulses");
    chk(cmd_dir, fwd, "direction");
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog: the run needs about 55000 cycles, the limit is 90000
  initial
  begin
    #1800000;
    num_errors++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    int n;
    logic [13:0] num;
    reset_dut();
    chk({cmd_step, motor_energized, brake_interlock_output, alarm.alarm}, 32'h0, "reset");
    // random ratios with remainder carried over the move
    repeat (5)
    begin
      seed = lfsr(seed);
      gear_cfg = '0;
      gear_cfg.num_one = {11'h0, seed[2:0]} + 14'h1;
      gear_cfg.num_two = {11'h0, seed[5:3]} + 14'h1;
      gear_cfg.num_exp = {4'h0, seed[6]};
      gear_cfg.den = {11'h0, seed[9:7]} + 14'h1;
      gear_cfg.gear_sel = seed[10];
      n = seed[12:11] + 1;
      num = seed[10] ? gear_cfg.num_two : gear_cfg.num_one;
      gear(n, seed[13], SGOB_IN_PULSE_DIR, gear_expect(n, num, gear_cfg.num_exp, gear_cfg.den));
    end
    gear_cfg = '0;
    gear_cfg.den = 14'h1388;
    gear_cfg.gear_sel = 1'b1;
    gear(3, 1'b1, SGOB_IN_PULSE_DIR, 32'h6);
    gear_cfg.gear_sel = 1'b0;
    gear_cfg.num_one = 14'h3FFF;
    gear_cfg.den = 14'h2710;
    gear(3, 1'b0, SGOB_IN_PULSE_DIR, 32'h3);
    gear_cfg.num_one = 14'h1;
    gear_cfg.num_exp = 5'h4;
    gear_cfg.den = 14'h0;
    gear(1, 1'b1, SGOB_IN_PULSE_DIR, 32'h10);
    gear_cfg.num_exp = 5'h0;
    gear(2, 1'b1, SGOB_IN_QUAD, 32'h4);
    gear_cfg.quad_x4 = 1'b1;
    gear(2, 1'b1, SGOB_IN_QUAD, 32'h8);
    gear(3, 1'b0, SGOB_IN_UPDOWN, 32'h3);
    // servo on refused at speed, then range grows with commands
    reset_dut();
    overrun_range_setting = 32'hA;
    motor_speed = 16'h0064;
    servo_on_req = 1'b1;
    tick(4);
    chk(motor_energized, 32'h0, "on at speed");
    motor_speed = 16'h001E;
    tick(4);
    chk({motor_energized, brake_interlock_output}, 32'h3, "servo on");
    command_pulse_mode = SGOB_IN_PULSE_DIR;
    i_host.send(5, 1'b1, SGOB_IN_PULSE_DIR);
    motor_position = 32'shF;
    tick(10);
    chk(alarm.alarm, 32'h0, "inside range");
    motor_position = -32'shB;
    tick(10);
    chk({alarm.alarm, alarm.code}, 32'h122, "overrun");
    // check idle outside position mode or with zero margin
    for (int k = 0; k < 2; k++)
    begin
      control_mode_select = k ? 4'h0 : 4'h1;
      overrun_range_setting = k ? 32'h0 : 32'hA;
      motor_position = 32'sh32;
      reset_dut();
      tick(10);
      chk(alarm.alarm, 32'h0, "check idle");
    end
    // stopped servo off, disarm, rearm by deviation clear
    control_mode_select = 4'h0;
    overrun_range_setting = 32'hA;
    motor_position = 32'sh0;
    reset_dut();
    tick(4);
    servo_on_req = 1'b0;
    tick(1);
    chk({motor_energized, brake_interlock_output}, 32'h2, "brake first");
    n = 0;
    while (motor_energized !== 1'b0 && n < 60000)
    begin
      tick(1);
      n++;
    end
    chk(motor_energized, 32'h0, "de-energize");
    // one millisecond is 50000 cycles of the 20 ns clock
    chk(n >= 50000 && n <= 50002, 32'h1, "stop delay");
    servo_on_req = 1'b1;
    motor_position = 32'sh32;
    tick(10);
    chk(alarm.alarm, 32'h0, "disarmed");
    deviation_clear = 1'b1;
    tick(2);
    deviation_clear = 1'b0;
    tick(10);
    chk({alarm.alarm, alarm.code}, 32'h122, "rearmed");
    // servo off while rotating
    motor_position = 32'sh0;
    reset_dut();
    tick(4);
    motor_speed = 16'h0064;
    servo_on_req = 1'b0;
    tick(20);
    chk({motor_energized, brake_interlock_output}, 32'h1, "running off");
    motor_speed = 16'h0014;
    tick(4);
    chk(brake_interlock_output, 32'h0, "slow brake");
    // servo back on stays disarmed until an autotune edge clears the range
    servo_on_req = 1'b1;
    motor_position = 32'sh32;
    tick(10);
    chk(alarm.alarm, 32'h0, "disarmed after run");
    autotune_active = 1'b1;
    tick(10);
    chk({alarm.alarm, alarm.code}, 32'h122, "rearm by tune");
    report_and_stop();
  end
endmodule

// ==== verilog/sgob_defines.svh ====
// constants for the servo gear, overrun and brake block
`ifndef SGOB_DEFINES_SVH
`define SGOB_DEFINES_SVH
`define SGOB_SET_MIN 14'h0001
`define SGOB_SET_MAX 14'h2710
`define SGOB_ENC_LINES 16'h09C4
`define SGOB_QUAD_FACTOR 3'h4
`define SGOB_STOP_SPEED 16'h001E
`define SGOB_MODE_POSITION 4'h0
`define SGOB_ALARM_OVERRUN 8'h22
`define SGOB_PROHIBIT_CLR 4'h2
`define SGOB_RANGE_LIMIT 32'h7FFFFFFF
`define SGOB_MS_NS 20'h0F4240
`define SGOB_CLK_NS 20'h00014
`define SGOB_MS_CYCLES (`SGOB_MS_NS / `SGOB_CLK_NS)
`endif

// ==== verilog/sgob_pkg.sv ====
// types for the servo gear, overrun and brake block
package sgob_pkg;
  typedef enum logic [1:0] {SGOB_IN_PULSE_DIR, SGOB_IN_QUAD, SGOB_IN_UPDOWN} sgob_pmode_t;
  typedef struct packed {
    logic [13:0] num_one;
    logic [13:0] num_two;
    logic [4:0] num_exp;
    logic [13:0] den;
    logic gear_sel;
    logic quad_x4;
  } sgob_gear_cfg_t;
  typedef struct packed {
    logic alarm;
    logic [7:0] code;
  } sgob_alarm_t;
endpackage

// ==== verilog/sgob_servo_logic.sv ====
// gear scaling, overrun limit and brake interlock sequencing of a servo drive
`timescale 1ns/1ps
`include "sgob_defines.svh"
module sgob_servo_logic
  import sgob_pkg::*;
#(
  parameter int ENC_LINES = 2500
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command pulse pins
  input wire logic cmd_a_pin,
  input wire logic cmd_b_pin,
  // settings
  input wire sgob_gear_cfg_t gear_cfg,
  input wire sgob_pmode_t command_pulse_mode,
  input wire logic [31:0] overrun_range_setting,
  input wire logic [3:0] control_mode_select,
  input wire logic [3:0] drive_prohibit_stop_select,
  input wire logic [15:0] stopped_brake_delay,
  input wire logic [15:0] running_brake_wait,
  // drive status
  input wire logic servo_on_req,
  input wire logic [15:0] motor_speed,
  input wire logic signed [31:0] motor_position,
  input wire logic deviation_clear,
  input wire logic autotune_active,
  // outputs
  output logic cmd_step,
  output logic cmd_dir,
  output logic signed [31:0] command_position,
  output logic motor_energized,
  output logic brake_interlock_output,
  output sgob_alarm_t alarm
);

  // clamp a setting into the legal range
  function automatic logic [13:0] clamp_set(input logic [13:0] v);
    clamp_set = (v < `SGOB_SET_MIN) ? `SGOB_SET_MIN : ((v > `SGOB_SET_MAX) ? `SGOB_SET_MAX : v);
  endfunction

  // input synchronisers
  logic [1:0] a_sync_q, b_sync_q;
  logic a_q, b_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_sync_q <= 2'h0;
      b_sync_q <= 2'h0;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      a_sync_q <= {a_sync_q[0], cmd_a_pin};
      b_sync_q <= {b_sync_q[0], cmd_b_pin};
      a_q <= a_sync_q[1];
      b_q <= b_sync_q[1];
    end
  end

  // pulse decode per input mode
  wire a_rise = a_sync_q[1] & ~a_q;
  wire a_edge = a_sync_q[1] ^ a_q;
  wire b_edge = b_sync_q[1] ^ b_q;
  wire quad_fwd = (a_edge & (a_sync_q[1] ^ b_sync_q[1])) | (b_edge & ~(a_sync_q[1] ^ b_sync_q[1]));
  wire quad_cnt = gear_cfg.quad_x4 ? (a_edge | b_edge) : a_edge;
  wire b_rise = b_sync_q[1] & ~b_q;
  wire in_pulse = (command_pulse_mode == SGOB_IN_QUAD) ? quad_cnt :
                  (command_pulse_mode == SGOB_IN_UPDOWN) ? (a_rise | b_rise) : a_rise;
  wire in_fwd = (command_pulse_mode == SGOB_IN_QUAD) ? quad_fwd :
                (command_pulse_mode == SGOB_IN_UPDOWN) ? a_rise : b_sync_q[1];

  // gear ratio selection
  wire [13:0] num_sel = gear_cfg.gear_sel ? gear_cfg.num_two : gear_cfg.num_one;
  wire [15:0] enc_res = 16'(ENC_LINES * `SGOB_QUAD_FACTOR);
  wire [13:0] num_lim = clamp_set(num_sel);
  wire [13:0] den_lim = clamp_set(gear_cfg.den);
  wire [47:0] num_eff = (num_sel == 14'h0000) ? {32'h0, enc_res} :
                        ({34'h0, num_lim} << gear_cfg.num_exp);
  wire [47:0] den_eff = {34'h0, den_lim};

  // gear accumulator: an input pulse adds numerator unless emitting, emits while at or above denominator
  logic [47:0] acc_q;
  logic acc_dir_q;
  logic signed [31:0] cmd_pos_q;
  wire acc_ge = acc_q >= den_eff;
  wire emit = acc_ge;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= 48'h0;
      acc_dir_q <= 1'b0;
    end
    else if (in_pulse && !acc_ge)
    begin
      // remainder of the last division stays in the accumulator unless the direction changes
      acc_q <= (in_fwd == acc_dir_q || acc_q == 48'h0) ? acc_q + num_eff : num_eff;
      acc_dir_q <= in_fwd;
    end
    else if (emit)
      acc_q <= acc_q - den_eff;
  end

  // internal command position and step outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_step <= 1'b0;
      cmd_dir <= 1'b0;
      cmd_pos_q <= 32'sh0;
    end
    else
    begin
      cmd_step <= emit;
      cmd_dir <= acc_dir_q;
      if (emit)
        cmd_pos_q <= acc_dir_q ? cmd_pos_q + 32'sh1 : cmd_pos_q - 32'sh1;
    end
  end
  assign command_position = cmd_pos_q;

  // range clear conditions
  logic tune_q;
  logic servo_q;
  logic on_q;
  wire tune_edge = autotune_active ^ tune_q;
  wire dev_clr = deviation_clear && (drive_prohibit_stop_select == `SGOB_PROHIBIT_CLR);
  wire range_clr = tune_edge | dev_clr;
  wire servo_off_edge = on_q & ~servo_q;
  wire set_zero = (overrun_range_setting == 32'h0);

  // command input range and check arm
  logic signed [31:0] rng_min_q, rng_max_q;
  logic armed_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rng_min_q <= 32'sh0;
      rng_max_q <= 32'sh0;
      armed_q <= 1'b1;
      tune_q <= 1'b0;
      on_q <= 1'b0;
    end
    else
    begin
      tune_q <= autotune_active;
      on_q <= servo_q;
      if (range_clr || !servo_q || set_zero)
      begin
        rng_min_q <= 32'sh0;
        rng_max_q <= 32'sh0;
      end
      else
      begin
        // range grows with commands in either direction
        if (cmd_pos_q < rng_min_q) rng_min_q <= cmd_pos_q;
        if (cmd_pos_q > rng_max_q) rng_max_q <= cmd_pos_q;
      end
      if (range_clr)
        armed_q <= 1'b1;
      else if (servo_off_edge)
        armed_q <= 1'b0;
    end
  end

  // allowable range with 34-bit headroom
  wire signed [33:0] lo_bound = 34'(rng_min_q) - $signed({2'b00, overrun_range_setting});
  wire signed [33:0] hi_bound = 34'(rng_max_q) + $signed({2'b00, overrun_range_setting});
  wire fits = (hi_bound <= 34'sh07FFFFFFF) && (lo_bound >= -34'sh07FFFFFFF);
  wire check_on = (control_mode_select == `SGOB_MODE_POSITION) && servo_q && !set_zero && fits && armed_q;
  wire signed [33:0] pos_ext = 34'(motor_position);
  wire outside = (pos_ext > hi_bound) || (pos_ext < lo_bound);

  // overrun alarm, held until reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      alarm <= '0;
    else if (check_on && outside)
    begin
      alarm.alarm <= 1'b1;
      alarm.code <= `SGOB_ALARM_OVERRUN;
    end
  end

  // brake sequencer
  typedef enum logic [2:0] {ST_OFF, ST_WAIT_SLOW, ST_ON, ST_STOP_DELAY, ST_RUN_WAIT} sgob_state_t;
  sgob_state_t st_q;
  logic [15:0] ms_q;
  logic [$clog2(`SGOB_MS_CYCLES)-1:0] tick_q;
  wire slow = motor_speed <= `SGOB_STOP_SPEED;
  wire ms_tick = (tick_q == ($clog2(`SGOB_MS_CYCLES))'(`SGOB_MS_CYCLES - 1));
  wire want_on = servo_on_req && !alarm.alarm;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_OFF;
      ms_q <= 16'h0;
      tick_q <= '0;
      servo_q <= 1'b0;
      motor_energized <= 1'b0;
      brake_interlock_output <= 1'b0;
    end
    else
    begin
      tick_q <= ms_tick ? '0 : tick_q + 1'b1;
      if (ms_tick && ms_q != 16'hFFFF)
        ms_q <= ms_q + 16'h1;
      case (st_q)
        ST_OFF:
          if (want_on && slow)
          begin
            st_q <= ST_ON;
            servo_q <= 1'b1;
            motor_energized <= 1'b1;
            brake_interlock_output <= 1'b1;
          end
        ST_ON:
          if (!want_on)
          begin
            ms_q <= 16'h0;
            tick_q <= '0;
            servo_q <= 1'b0;
            if (slow)
            begin
              brake_interlock_output <= 1'b0;
              st_q <= ST_STOP_DELAY;
            end
            else
            begin
              motor_energized <= 1'b0;
              st_q <= ST_RUN_WAIT;
            end
          end
        ST_STOP_DELAY:
          if (ms_q >= stopped_brake_delay)
          begin
            motor_energized <= 1'b0;
            st_q <= ST_OFF;
          end
        ST_RUN_WAIT:
          if (slow || ms_q >= running_brake_wait)
          begin
            brake_interlock_output <= 1'b0;
            st_q <= ST_OFF;
          end
        default:
          st_q <= ST_OFF;
      endcase
    end
  end

  // checks
  a_brake_first: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(motor_energized) && $past(st_q) == ST_STOP_DELAY |-> !brake_interlock_output)
    else $error("motor de-energized before brake output off");
  a_servo_on_slow: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(servo_q) |-> $past(motor_speed) <= `SGOB_STOP_SPEED)
    else $error("servo on at high speed");
  a_run_brake_off: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_RUN_WAIT && slow |=> !brake_interlock_output)
    else $error("brake output stays on while slow");
  a_alarm_code: assert property (@(posedge clk) disable iff (!rst_n)
    check_on && outside |=> alarm.alarm && alarm.code == `SGOB_ALARM_OVERRUN)
    else $error("overrun alarm missing");
  a_mode_gate: assert property (@(posedge clk) disable iff (!rst_n)
    control_mode_select != `SGOB_MODE_POSITION |-> !check_on)
    else $error("check active outside position mode");
  a_range_clear: assert property (@(posedge clk) disable iff (!rst_n)
    !servo_q || set_zero |=> rng_min_q == 32'sh0 && rng_max_q == 32'sh0)
    else $error("range not cleared");
  a_disarm_hold: assert property (@(posedge clk) disable iff (!rst_n)
    servo_off_edge && !range_clr |=> !armed_q)
    else $error("check not disarmed at servo off");
  a_gear_remainder: assert property (@(posedge clk) disable iff (!rst_n)
    emit |=> acc_q == $past(acc_q) - $past(den_eff))
    else $error("remainder not kept");
  a_range_grow: assert property (@(posedge clk) disable iff (!rst_n)
    servo_q && !set_zero && !range_clr |=> rng_max_q >= $past(rng_max_q))
    else $error("range shrank");
  a_sel_num: assert property (@(posedge clk) disable iff (!rst_n)
    gear_cfg.gear_sel && gear_cfg.num_two == 14'h0 |-> num_eff == {32'h0, enc_res})
    else $error("gear numerator selection wrong");
  a_limit_fit: assert property (@(posedge clk) disable iff (!rst_n)
    !fits |-> !check_on)
    else $error("check on with range beyond limit");
  // stop request with the motor slow: brake output turned off first, motor kept energized
  sequence s_stop_request;
    st_q == ST_ON && !want_on && slow;
  endsequence
  a_stop_order: assert property (@(posedge clk) disable iff (!rst_n)
    s_stop_request |=> !brake_interlock_output && motor_energized && st_q == ST_STOP_DELAY)
    else $error("stop order wrong");

endmodule
